// *** src/dac_pin_mode_control_port.sv ***
// What this block does
// - Strap low: serial port; high: pin control
// - Serial mode: open-drain low-active interrupt output
// - Pin mode: interrupt pin selects sample format
// - Serial mode: reset pin high resets device
// - Pin mode: reset pin high holds power-down
// - Fourteen differential data bits, bit 13 MSB
// - Device drives differential output data clock
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module dac_pin_mode_control_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap and shared control pins
  input wire logic mode_strap_i,
  input wire logic irq_pin_i,
  output logic irq_pin_o,
  output logic irq_pin_oe_o,
  input wire logic reset_pin_i,
  input wire logic serial_select_n_i,
  input wire logic serial_data_io_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_out_i,
  // Differential sample link
  input wire logic [pin_mux_pkg::SAMPLE_W-1:0] sample_bus_p_i,
  input wire logic [pin_mux_pkg::SAMPLE_W-1:0] sample_bus_n_i,
  input wire logic sample_capture_clock_in_p_i,
  input wire logic sample_capture_clock_in_n_i,
  output logic source_timing_clock_out_p_o,
  output logic source_timing_clock_out_n_o,
  input wire logic conversion_clock_p_i,
  input wire logic conversion_clock_n_i,
  // Results toward the converter core
  output pin_mux_pkg::pin_cfg_t cfg_o,
  output logic device_reset_o,
  output logic [pin_mux_pkg::SAMPLE_W-1:0] sample_word_o,
  output logic sample_valid_o,
  output logic irq_o
);
  import pin_mux_pkg::*;
  // Differential receiver: a one needs p high and n low
  function automatic logic [SAMPLE_W-1:0] lvds_rx(
    input logic [SAMPLE_W-1:0] p,
    input logic [SAMPLE_W-1:0] n
  );
    lvds_rx = p & ~n;
  endfunction
  // Address decode shared by the write and read paths
  function automatic reg_sel_t reg_sel(input logic [31:0] addr);
    case (addr)
      ADDR_CTRL: reg_sel = SEL_CTRL;
      ADDR_STATUS: reg_sel = SEL_STATUS;
      ADDR_MASK: reg_sel = SEL_MASK;
      ADDR_PINS: reg_sel = SEL_PINS;
      ADDR_SAMPLE: reg_sel = SEL_SAMPLE;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction
  // Raw levels from the pads
  logic [SAMPLE_W-1:0] bus_raw; // Decoded data pairs
  logic [SAMPLE_W-1:0] dclk_raw; // Input data clock in bit 0
  logic [SAMPLE_W-1:0] cclk_raw; // Conversion clock in bit 0
  logic [8:0] pins_raw; // Single-ended control pins plus both decoded clocks
  logic [8:0] pins_s; // Same pins, synchronised
  logic [SAMPLE_W-1:0] bus_s; // Data, synchronised
  logic dclk_s; // Input data clock, synchronised
  logic cclk_s; // Conversion clock, synchronised
  assign bus_raw = lvds_rx(sample_bus_p_i, sample_bus_n_i);
  assign dclk_raw = lvds_rx({{(SAMPLE_W-1){1'b0}}, sample_capture_clock_in_p_i},
    {{(SAMPLE_W-1){1'b0}}, sample_capture_clock_in_n_i});
  assign cclk_raw = lvds_rx({{(SAMPLE_W-1){1'b0}}, conversion_clock_p_i},
    {{(SAMPLE_W-1){1'b0}}, conversion_clock_n_i});
  assign pins_raw = {cclk_raw[0], dclk_raw[0], mode_strap_i, irq_pin_i, reset_pin_i,
    serial_select_n_i, serial_data_io_i, serial_clock_i, serial_data_out_i};
  // Every pad input crosses in through four flops
  sync3 #(.W(9)) u_pin_sync (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );
  // Data bus crosses with the same latency as its clock
  sync3 #(.W(SAMPLE_W)) u_bus_sync (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(bus_raw),
    .q_o(bus_s)
  );
  assign cclk_s = pins_s[8];
  assign dclk_s = pins_s[7];
  // Register state
  logic strap_r; // Latched mode strap
  logic [CTRL_W-1:0] ctrl_r; // Software control
  logic [STAT_W-1:0] status_r; // Sticky events
  logic [STAT_W-1:0] mask_r; // Interrupt enables
  logic [STAT_W-1:0] events; // One-cycle event pulses
  logic [STAT_W-1:0] w1c; // Bits cleared by this write
  logic pd_prev_r; // Power-down history for edge event
  logic rst_prev_r; // Reset pin history for edge event
  logic pending; // Any unmasked event pending
  logic fmt_unsigned; // Sample format in force
  logic cap_word_valid; // Pulse from the capture unit
  logic [SAMPLE_W-1:0] cap_word; // Raw captured word
  // Strap is caught only while system reset is held; later moves are ignored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_r <= pins_s[6];
    end
  end
  // Shared-pin meanings follow the strap
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_o <= CFG_RST;
    end else if (strap_r) begin
      // Pin mode: serial port off, every shared pin is a direct select
      cfg_o.serial_en <= 1'b0;
      cfg_o.fmt_unsigned <= pins_s[5];
      cfg_o.power_down <= pins_s[4];
      cfg_o.interp_en <= pins_s[3];
      cfg_o.fifo_en <= pins_s[2];
      cfg_o.full_scale <= {pins_s[0], pins_s[1]};
    end else begin
      // Serial mode: format and power-down come from software
      cfg_o.serial_en <= 1'b1;
      cfg_o.fmt_unsigned <= ctrl_r[CTRL_FMT];
      cfg_o.power_down <= ctrl_r[CTRL_PD];
      cfg_o.interp_en <= 1'b0;
      cfg_o.fifo_en <= 1'b0;
      cfg_o.full_scale <= 2'h0;
    end
  end
  // Device reset follows the reset pin only in serial mode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      device_reset_o <= 1'b1;
    end else begin
      device_reset_o <= ~strap_r & pins_s[4];
    end
  end
  assign fmt_unsigned = cfg_o.fmt_unsigned;
  // Capture unit is held off while reset or powered down
  word_capture u_capture (
    .clk_i(sys_clk_i),
    .rst_i(rst_i | device_reset_o),
    .enable_i(ctrl_r[CTRL_CAP_EN] & ~cfg_o.power_down),
    .link_clk_i(dclk_s),
    .data_i(bus_s),
    .word_o(cap_word),
    .valid_o(cap_word_valid)
  );
  // Words go out as offset binary; two's complement flips the top bit
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || device_reset_o) begin
      sample_word_o <= '0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= cap_word_valid;
      if (cap_word_valid) begin
        sample_word_o <= {cap_word[SAMPLE_W-1] ^ ~fmt_unsigned,
          cap_word[SAMPLE_W-2:0]};
      end
    end
  end
  // Output data clock echoes the conversion clock so the source can pace words
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || device_reset_o || cfg_o.power_down) begin
      source_timing_clock_out_p_o <= 1'b0;
      source_timing_clock_out_n_o <= 1'b1;
    end else if (ctrl_r[CTRL_CLK_EN]) begin
      source_timing_clock_out_p_o <= cclk_s;
      source_timing_clock_out_n_o <= ~cclk_s;
    end else begin
      source_timing_clock_out_p_o <= 1'b0;
      source_timing_clock_out_n_o <= 1'b1;
    end
  end
  // Edge history for power-down and reset events
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pd_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else begin
      pd_prev_r <= cfg_o.power_down;
      rst_prev_r <= device_reset_o;
    end
  end
  assign events[STAT_CAPTURE] = sample_valid_o;
  assign events[STAT_PD] = cfg_o.power_down & ~pd_prev_r;
  assign events[STAT_RESET] = ~device_reset_o & rst_prev_r;
  // Bus write channel state
  logic aw_held_r; // Write address taken
  logic w_held_r; // Write data taken
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write; // Both halves present, response slot free
  reg_sel_t wsel; // Decoded write target
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wsel = reg_sel(awaddr_r);
  // Address and data are taken independently, in either order
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Ready drops the cycle after a take and returns once the response is gone
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready)
        & ~s_axi_bvalid & ~do_write;
      s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready)
        & ~s_axi_bvalid & ~do_write;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; only the low byte holds fields
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || device_reset_o) begin
      ctrl_r <= CTRL_RST;
    end else if (do_write && wsel == SEL_CTRL && wstrb_r[0]) begin
      ctrl_r <= wdata_r[CTRL_W-1:0];
    end
  end

  // Mask register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RST;
    end else if (do_write && wsel == SEL_MASK && wstrb_r[0]) begin
      mask_r <= wdata_r[STAT_W-1:0];
    end
  end

  assign w1c = (do_write && wsel == SEL_STATUS && wstrb_r[0]) ?
    wdata_r[STAT_W-1:0] : '0;

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_r <= STAT_RST;
    end else begin
      status_r <= (status_r & ~w1c) | events;
    end
  end

  assign pending = |(status_r & mask_r);

  // Interrupt output toward the system
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= pending;
    end
  end

  // Open-drain pin pulls low only in serial mode while pending
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_pin_o <= 1'b0;
      irq_pin_oe_o <= 1'b0;
    end else begin
      irq_pin_o <= 1'b0;
      irq_pin_oe_o <= ~strap_r & pending;
    end
  end

  // Read channel
  reg_sel_t rsel; // Decoded read target
  logic [31:0] rdata; // Read mux result

  assign rsel = reg_sel(s_axi_araddr);

  // Read mux; reserved bits read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (rsel)
      SEL_CTRL: rdata[CTRL_W-1:0] = ctrl_r;
      SEL_STATUS: rdata[STAT_W-1:0] = status_r;
      SEL_MASK: rdata[STAT_W-1:0] = mask_r;
      SEL_PINS: rdata[8:0] = {device_reset_o, strap_r, cfg_o};
      SEL_SAMPLE: rdata[SAMPLE_W-1:0] = sample_word_o;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // One read at a time; the answer follows the take by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata;
      s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** src/pin_mux_pkg.sv ***
`default_nettype none
package pin_mux_pkg;
  // Sample word width on the differential bus
  localparam int unsigned SAMPLE_W = 14;
  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_MASK = 32'h0000_0008;
  localparam logic [31:0] ADDR_PINS = 32'h0000_000C;
  localparam logic [31:0] ADDR_SAMPLE = 32'h0000_0010;
  // Control register fields and reset value
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CTRL_CAP_EN = 0;
  localparam int unsigned CTRL_CLK_EN = 1;
  localparam int unsigned CTRL_FMT = 2;
  localparam int unsigned CTRL_PD = 3;
  localparam logic [3:0] CTRL_RST = 4'h3;
  // Event bits, shared by status and mask
  localparam int unsigned STAT_W = 3;
  localparam int unsigned STAT_CAPTURE = 0;
  localparam int unsigned STAT_PD = 1;
  localparam int unsigned STAT_RESET = 2;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register selector
  typedef enum {SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_PINS, SEL_SAMPLE, SEL_NONE} reg_sel_t;
  // Pin-derived configuration carried as one word
  typedef struct packed {
    logic serial_en;
    logic fmt_unsigned;
    logic power_down;
    logic interp_en;
    logic fifo_en;
    logic [1:0] full_scale;
  } pin_cfg_t;
  localparam pin_cfg_t CFG_RST = 7'h00;
endpackage
`default_nettype wire

// *** src/sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] ff1_r; // Metastable stage, read only by ff2
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;

  // Three-stage shift, never cleared: a strap must reach the output while reset is held
  always_ff @(posedge clk_i) begin
    ff1_r <= d_i;
    ff2_r <= ff1_r;
    ff3_r <= ff2_r;
  end

  // A change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        // Reset loads the output from stage three, so the pin level is known at release
        q_o[i] <= ff3_r[i];
      end else if (ff2_r[i] == ff3_r[i]) begin
        q_o[i] <= ff3_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** src/word_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
module word_capture (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic link_clk_i,
  input wire logic [pin_mux_pkg::SAMPLE_W-1:0] data_i,
  output logic [pin_mux_pkg::SAMPLE_W-1:0] word_o,
  output logic valid_o
);
  import pin_mux_pkg::*;

  logic link_prev_r; // Last seen link clock level
  logic rise; // Rising edge of the link clock

  assign rise = link_clk_i & ~link_prev_r;

  // Edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= link_clk_i;
    end
  end

  // Data and clock share synchroniser latency, so the word is stable at the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= rise & enable_i;
      if (rise && enable_i) begin
        word_o <= data_i;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/dac_pin_mode_control_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dac_pin_mode_control_port_tb;
  import pin_mux_pkg::*;
  // Clock, reset, bus master
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Strap and static pins
  logic mode_strap_i = 1'b0, fmt_drive = 1'b0, reset_pin_i = 1'b0;
  logic serial_select_n_i = 1'b1, serial_data_io_i = 1'b0;
  logic serial_clock_i = 1'b0, serial_data_out_i = 1'b0;
  logic irq_pin_o, irq_pin_oe_o, irq_pin_i;
  // Link pins and results
  logic [SAMPLE_W-1:0] sample_bus_p_i, sample_bus_n_i, sample_word_o;
  logic sample_capture_clock_in_p_i, sample_capture_clock_in_n_i;
  logic conversion_clock_p_i, conversion_clock_n_i;
  logic source_timing_clock_out_p_o, source_timing_clock_out_n_o;
  logic device_reset_o, sample_valid_o, irq_o;
  pin_cfg_t cfg_o;
  int bad_count = 0;
  int compares = 0;
  // Pull-up in serial mode; the bench drives the format level in pin mode
  assign irq_pin_i = mode_strap_i ? fmt_drive : (irq_pin_oe_o ? irq_pin_o : 1'b1);
  always #2 sys_clk_i = ~sys_clk_i;
  dac_pin_mode_control_port uut (.sys_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_strap_i, .irq_pin_i,
    .irq_pin_o, .irq_pin_oe_o, .reset_pin_i, .serial_select_n_i, .serial_data_io_i,
    .serial_clock_i, .serial_data_out_i, .sample_bus_p_i, .sample_bus_n_i,
    .sample_capture_clock_in_p_i, .sample_capture_clock_in_n_i, .source_timing_clock_out_p_o,
    .source_timing_clock_out_n_o, .conversion_clock_p_i, .conversion_clock_n_i, .cfg_o,
    .device_reset_o, .sample_word_o, .sample_valid_o, .irq_o);
  sample_source_model src (.bus_p_o(sample_bus_p_i), .bus_n_o(sample_bus_n_i),
    .clk_p_o(sample_capture_clock_in_p_i), .clk_n_o(sample_capture_clock_in_n_i),
    .conv_p_o(conversion_clock_p_i), .conv_n_o(conversion_clock_n_i));
  // Four-state compare, so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Strap is latched while reset is held
  task automatic do_reset(input logic strap);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    mode_strap_i <= strap;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_p, w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw_p || w_p) && n < 200) begin
      @(posedge sys_clk_i);
      n++;
      if (aw_p && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    s_axi_bready <= 1'b0;
    chk({29'h0, n >= 200, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 200);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({29'h0, n >= 200, s_axi_rresp}, {30'h0, er});
  endtask
  // Send a word and watch a bounded window for its capture
  task automatic send_chk(input logic [13:0] w, input logic expv, input logic [13:0] ew);
    logic seen;
    logic [SAMPLE_W-1:0] got;
    seen = 1'b0;
    got = '0;
    fork
      src.send_word(w);
      repeat (40) begin
        @(posedge sys_clk_i);
        if (!seen && sample_valid_o === 1'b1) begin
          seen = 1'b1;
          got = sample_word_o;
        end
      end
    join
    chk({31'h0, seen}, {31'h0, expv});
    if (expv) chk({18'h0, got}, {18'h0, ew});
  endtask
  // Serial mode: registers, capture, interrupt pin, device reset
  task automatic t_serial();
    chk({31'h0, cfg_o.serial_en}, 32'h0000_0001);
    axi_rd(ADDR_CTRL, {28'h0, CTRL_RST}, RESP_OKAY);
    axi_wr(32'h0000_0020, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(32'h0000_0020, 32'h0000_0000, RESP_SLVERR);
    axi_wr(ADDR_MASK, 32'h0000_0001, RESP_OKAY);
    send_chk(14'h2ABC, 1'b1, 14'h0ABC);
    repeat (4) @(posedge sys_clk_i);
    chk({30'h0, irq_o, irq_pin_oe_o}, 32'h0000_0003);
    chk({31'h0, irq_pin_i}, 32'h0000_0000);
    axi_wr(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (4) @(posedge sys_clk_i);
    chk({30'h0, irq_o, irq_pin_oe_o}, 32'h0000_0000);
    axi_wr(ADDR_CTRL, 32'h0000_0007, RESP_OKAY);
    send_chk(14'h0001, 1'b1, 14'h0001);
    reset_pin_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk({30'h0, device_reset_o, source_timing_clock_out_p_o}, 32'h0000_0002);
    send_chk(14'h1234, 1'b0, 14'h0000);
    reset_pin_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk({31'h0, device_reset_o}, 32'h0000_0000);
    axi_rd(ADDR_CTRL, {28'h0, CTRL_RST}, RESP_OKAY);
  endtask
  // Output data clock p leg toggles more than four times in 100 cycles
  task automatic t_clk_out();
    int tog;
    logic last;
    tog = 0;
    last = source_timing_clock_out_p_o;
    repeat (100) begin
      @(posedge sys_clk_i);
      if (source_timing_clock_out_p_o !== last) tog++;
      last = source_timing_clock_out_p_o;
    end
    chk({31'h0, tog > 4}, 32'h0000_0001);
  endtask
  // Pin mode: static selects, format pin, power down
  task automatic t_pin();
    do_reset(1'b1);
    fmt_drive <= 1'b1;
    serial_select_n_i <= 1'b1;
    serial_clock_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk({25'h0, cfg_o}, 32'h0000_0029);
    fmt_drive <= 1'b0;
    serial_select_n_i <= 1'b0;
    serial_data_io_i <= 1'b1;
    serial_clock_i <= 1'b0;
    serial_data_out_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk({25'h0, cfg_o}, 32'h0000_0006);
    axi_wr(ADDR_MASK, 32'h0000_0001, RESP_OKAY);
    send_chk(14'h3FFF, 1'b1, 14'h1FFF);
    repeat (4) @(posedge sys_clk_i);
    chk({30'h0, irq_o, irq_pin_oe_o}, 32'h0000_0002);
    fmt_drive <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    send_chk(14'h3FFF, 1'b1, 14'h3FFF);
    reset_pin_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk({29'h0, cfg_o.power_down, device_reset_o, source_timing_clock_out_p_o}, 32'h0000_0004);
    send_chk(14'h0F0F, 1'b0, 14'h0000);
    reset_pin_i <= 1'b0;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b0);
    t_serial();
    t_clk_out();
    t_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** test/pin_mux_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_mux_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_o,
  input wire logic source_timing_clock_out_p_o,
  input wire logic source_timing_clock_out_n_o,
  input wire pin_mux_pkg::pin_cfg_t cfg_o,
  input wire logic device_reset_o,
  input wire logic [pin_mux_pkg::SAMPLE_W-1:0] sample_word_o,
  input wire logic sample_valid_o,
  input wire logic irq_o
);
  import pin_mux_pkg::*;
  // One domain only
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_pin_pull_low: assert property (irq_pin_oe_o |-> !irq_pin_o)
    else $error("interrupt pin driven high");
  a_oe_serial_only: assert property (irq_pin_oe_o |-> cfg_o.serial_en)
    else $error("interrupt pin driven in pin mode");
  a_irq_reaches_pin: assert property ($rose(irq_o) && cfg_o.serial_en |-> ##[0:2] irq_pin_oe_o)
    else $error("pending interrupt not on pin");
  a_reset_clears_pd: assert property (device_reset_o [*3] |-> !cfg_o.power_down)
    else $error("power down kept through reset");
  a_clk_out_pair: assert property (source_timing_clock_out_n_o != source_timing_clock_out_p_o)
    else $error("clock out legs not complementary");
  a_clk_out_quiet: assert property
    ((device_reset_o || cfg_o.power_down) [*3] |-> !source_timing_clock_out_p_o)
    else $error("clock out runs while held");
  a_valid_one_cycle: assert property (sample_valid_o |=> !sample_valid_o)
    else $error("capture pulse too long");
  a_word_on_capture: assert property
    (!device_reset_o && $changed(sample_word_o) |-> sample_valid_o)
    else $error("word changed without capture");
endmodule
bind dac_pin_mode_control_port pin_mux_checker chk (.sys_clk_i, .rst_i, .irq_pin_o,
  .irq_pin_oe_o, .source_timing_clock_out_p_o, .source_timing_clock_out_n_o, .cfg_o,
  .device_reset_o, .sample_word_o, .sample_valid_o, .irq_o);
`default_nettype wire

// *** test/sample_source_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sample_source_model (
  output logic [pin_mux_pkg::SAMPLE_W-1:0] bus_p_o,
  output logic [pin_mux_pkg::SAMPLE_W-1:0] bus_n_o,
  output logic clk_p_o,
  output logic clk_n_o,
  output logic conv_p_o,
  output logic conv_n_o
);
  import pin_mux_pkg::*;
  // Link clock rests low between words
  initial begin
    bus_p_o = '0;
    bus_n_o = '1;
    clk_p_o = 1'b0;
    clk_n_o = 1'b1;
    conv_p_o = 1'b0;
    conv_n_o = 1'b1;
  end
  // Conversion clock, free running and unrelated
  always #20 begin
    conv_p_o = ~conv_p_o;
    conv_n_o = ~conv_n_o;
  end
  // One word per 64 ns link period, settled well before the rise
  task automatic send_word(input logic [SAMPLE_W-1:0] w);
    // Step off the system clock edge, so no pin change races a sample
    #1;
    bus_p_o = w;
    bus_n_o = ~w;
    #32;
    clk_p_o = 1'b1;
    clk_n_o = 1'b0;
    #32;
    clk_p_o = 1'b0;
    clk_n_o = 1'b1;
    #16;
    // Released bus shows the inverse, so stale data cannot pass
    bus_p_o = ~w;
    bus_n_o = w;
  endtask
endmodule
`default_nettype wire
